/* src/ics_pkg.sv */
// Purpose: constants and carriers for the interrupt sequencer
// Assumes: 250 MHz aclk, AXI4-Lite register access
// Notes:   cycle counts are in aclk cycles
`default_nettype none
package ics_pkg;
  localparam int          NUM_SRC       = 8;
  localparam int          PC_W          = 9;
  localparam int          PROG_WORDS    = 512;
  localparam int          CNT_W         = 4;
  localparam int          AXI_AW        = 8;
  // vector map, lowest address first
  localparam logic [8:0]  VEC_RESET     = 9'h000;
  localparam logic [8:0]  VEC_FIRST_IRQ = 9'h001;
  // sequencing lengths in cycles
  localparam logic [3:0]  ENTRY_CYC     = 4'h4;
  localparam logic [3:0]  SLEEP_EXTRA   = 4'h4;
  localparam logic [3:0]  JUMP_CYC      = 4'h3;
  localparam logic [3:0]  RETURN_FROM_INTERRUPT_INSTR_CYC      = 4'h4;
  localparam logic [7:0]  SP_RESET      = 8'h9F;
  localparam logic [7:0]  SP_STEP       = 8'h01;
  localparam logic [7:0]  SP_FRAME      = 8'h02;
  localparam int          GIE_BIT       = 7;
  localparam logic [6:0]  PC_HI_PAD     = 7'h00;
  // register offsets
  localparam logic [7:0]  OFS_FLAGREG   = 8'h00;
  localparam logic [7:0]  OFS_IEN       = 8'h04;
  localparam logic [7:0]  OFS_IFLAG     = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;
  localparam logic [7:0]  OFS_RETPC     = 8'h10;
  localparam int          ST_BUSY_BIT   = 8;
  localparam int          ST_SKIP_BIT   = 9;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    ICS_RESET,
    ICS_RUN,
    ICS_ENTRY,
    ICS_JUMP,
    ICS_RETURN
  } ics_state_t;

  // stack memory port toward data sram
  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ics_stk_t;

  // reload request toward the fetch unit
  typedef struct packed {
    logic            load;
    logic [PC_W-1:0] addr;
  } ics_pcld_t;
endpackage
`default_nettype wire

/* src/ics_sequencer.sv */
// Purpose: reset and interrupt sequencing for a small 8-bit core
// Assumes: request sources and pipeline run on aclk; stack reads
//          return data one cycle after stk.re
// Notes:   registers reached over AXI4-Lite
//
// Notes on behaviour
// - lowest vector address wins; reset first
// - take only if source and global enabled
// - accepting an interrupt clears global enable
// - global enable inside handler allows nesting
// - return instruction sets global enable
// - vectoring clears the served flag
// - writing one clears flag, zero keeps
// - disabled flag events stay pending
// - level sources request only while present
// - one instruction runs after return first
// - flag register never saved or restored
// - clear-enable instruction masks same cycle
// - instruction after set-enable runs first
// - entry four cycles, pushing program counter
// - vector jump lasts three cycles
// - multi-cycle instruction completes before entry
// - wake from sleep adds four cycles
// - return four cycles, pops pc, sp+2
// - runs directly on the core clock
// - nine-bit program counter, 512 words
// - entry push decrements stack pointer two
// - global enable is flag register bit 7
`default_nettype none
module ics_sequencer
  import ics_pkg::*;
#(
  parameter int          NS         = NUM_SRC,
  parameter logic [NS-1:0] LEVEL_MASK = '0
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // peripheral requests
  input  wire logic [NS-1:0] flag_set,
  input  wire logic [NS-1:0] level_req,
  // pipeline side
  input  wire logic          instr_done,
  input  wire logic          cli_exec,
  input  wire logic          sei_exec,
  input  wire logic          return_from_interrupt_instr_exec,
  input  wire logic          core_sleep,
  input  wire logic [8:0]    program_counter,
  output logic               core_hold,
  output logic               core_wake,
  output logic               vector_exec,
  output ics_pcld_t          pc_reload,
  // stack side
  output ics_stk_t           stk,
  input  wire logic [7:0]    stk_rdata,
  // axi4-lite slave
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);
  localparam int SW = (NS > 1) ? $clog2(NS) : 1;

  typedef struct packed {
    ics_state_t      st;
    logic [3:0]      cnt;
    logic [3:0]      len;
    logic            gie;
    logic            skip;
    logic [NS-1:0]   ien;
    logic [NS-1:0]   flg;
    logic [7:0]      sp;
    logic [PC_W-1:0] ret;
    logic [PC_W-1:0] vec;
    logic            wake;
    ics_pcld_t       pcld;
    ics_stk_t        stk;
    logic            aw_got;
    logic [7:0]      awaddr;
    logic            w_got;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } ics_reg_t;

  ics_reg_t r;
  ics_reg_t next_r;

  logic [NS-1:0] pend;
  logic          any_pend;
  logic [SW-1:0] sel;
  logic          gie_now;
  logic          boundary;
  logic          take;
  logic [31:0]   bmask;
  logic [31:0]   wd;
  logic [31:0]   rd_word;
  logic          rd_err;
  logic          wr_flag;
  logic          wr_ien;
  logic          wr_iflag;
  logic          wr_err;

  // request vector: flags for edge sources, live level otherwise
  always_comb begin
    pend = ((r.flg & ~LEVEL_MASK) | (level_req & LEVEL_MASK)) & r.ien;
    any_pend = |pend;
    sel = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel = SW'(i);
      end
    end
  end

  // entry decision at instruction boundaries only
  always_comb begin
    gie_now  = r.gie & ~cli_exec;
    boundary = (instr_done | core_sleep) & ~r.skip;
    take     = (r.st == ICS_RUN) & boundary & gie_now & any_pend;
  end

  always_comb begin
    bmask = {{8{r.wstrb[3]}}, {8{r.wstrb[2]}}, {8{r.wstrb[1]}}, {8{r.wstrb[0]}}};
    wd    = r.wdata & bmask;
  end

  // write decode of the captured address
  always_comb begin
    wr_flag  = 1'b0;
    wr_ien   = 1'b0;
    wr_iflag = 1'b0;
    wr_err   = 1'b0;
    case (r.awaddr)
      OFS_FLAGREG: begin
        wr_flag = 1'b1;
      end
      OFS_IEN: begin
        wr_ien = 1'b1;
      end
      OFS_IFLAG: begin
        wr_iflag = 1'b1;
      end
      OFS_STATUS, OFS_RETPC: begin
        wr_err = 1'b0;
      end
      default: begin
        wr_err = 1'b1;
      end
    endcase
  end

  // read mux over the current register values
  always_comb begin
    rd_word = '0;
    rd_err  = 1'b0;
    case (s_axi_araddr)
      OFS_FLAGREG: begin
        rd_word[GIE_BIT] = r.gie;
      end
      OFS_IEN: begin
        rd_word[NS-1:0] = r.ien;
      end
      OFS_IFLAG: begin
        rd_word[NS-1:0] = r.flg;
      end
      OFS_STATUS: begin
        rd_word[7:0]         = r.sp;
        rd_word[ST_BUSY_BIT] = (r.st != ICS_RUN);
        rd_word[ST_SKIP_BIT] = r.skip;
      end
      OFS_RETPC: begin
        rd_word[PC_W-1:0] = r.ret;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.pcld.load = 1'b0;
    next_r.wake      = 1'b0;
    next_r.stk.we    = 1'b0;
    next_r.stk.re    = 1'b0;

    // ---- sequencer ----
    case (r.st)
      ICS_RESET: begin
        next_r.pcld.load = 1'b1;
        next_r.pcld.addr = VEC_RESET;
        next_r.st        = ICS_RUN;
      end
      ICS_RUN: begin
        if (instr_done) begin
          next_r.skip = 1'b0;
        end
        if (cli_exec) begin
          next_r.gie = 1'b0;
        end
        if (sei_exec) begin
          next_r.gie  = 1'b1;
          next_r.skip = 1'b1;
        end
        if (take) begin
          next_r.st   = ICS_ENTRY;
          next_r.cnt  = '0;
          next_r.len  = core_sleep ? ENTRY_CYC + SLEEP_EXTRA : ENTRY_CYC;
          next_r.wake = core_sleep;
          next_r.gie  = 1'b0;
          next_r.ret  = program_counter;
          next_r.vec  = VEC_FIRST_IRQ + PC_W'(sel);
        end else if (return_from_interrupt_instr_exec & instr_done) begin
          next_r.st  = ICS_RETURN;
          next_r.cnt = '0;
        end
      end
      ICS_ENTRY: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == '0) begin
          next_r.stk.we    = 1'b1;
          next_r.stk.addr  = r.sp;
          next_r.stk.wdata = r.ret[7:0];
        end
        if (r.cnt == 4'h1) begin
          next_r.stk.we    = 1'b1;
          next_r.stk.addr  = r.sp - SP_STEP;
          next_r.stk.wdata = {PC_HI_PAD, r.ret[8]};
          next_r.sp        = r.sp - SP_FRAME;
        end
        if (r.cnt == r.len - 4'h1) begin
          next_r.pcld.load = 1'b1;
          next_r.pcld.addr = r.vec;
          next_r.st        = ICS_JUMP;
          next_r.cnt       = '0;
        end
      end
      ICS_JUMP: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == JUMP_CYC - 4'h1) begin
          next_r.st   = ICS_RUN;
          next_r.skip = 1'b0;
        end
      end
      ICS_RETURN: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == '0) begin
          next_r.stk.re   = 1'b1;
          next_r.stk.addr = r.sp + SP_STEP;
        end
        if (r.cnt == 4'h1) begin
          next_r.stk.re   = 1'b1;
          next_r.stk.addr = r.sp + SP_FRAME;
        end
        // read data trails its strobe by one cycle
        if (r.cnt == 4'h2) begin
          next_r.ret[8] = stk_rdata[0];
        end
        if (r.cnt == RETURN_FROM_INTERRUPT_INSTR_CYC - 4'h1) begin
          next_r.ret[7:0]  = stk_rdata;
          next_r.sp        = r.sp + SP_FRAME;
          next_r.gie       = 1'b1;
          next_r.skip      = 1'b1;
          next_r.pcld.load = 1'b1;
          next_r.pcld.addr = {r.ret[8], stk_rdata};
          next_r.st        = ICS_RUN;
        end
      end
      default: begin
        next_r.st = ICS_RESET;
      end
    endcase

    // ---- axi4-lite slave ----
    if (s_axi_awvalid & s_axi_awready) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid & s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_got & r.w_got & ~r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = wr_err ? RESP_SLVERR : RESP_OKAY;
      if (wr_flag & r.wstrb[0] & ~take) begin
        next_r.gie  = r.wdata[GIE_BIT];
        next_r.skip = r.wdata[GIE_BIT] & ~r.gie;
      end
      if (wr_ien) begin
        next_r.ien = (r.ien & ~NS'(bmask)) | NS'(wd);
      end
      if (wr_iflag) begin
        next_r.flg = next_r.flg & ~NS'(wd);
      end
    end

    // flags: hardware set beats any clear in the same cycle
    if (take) begin
      next_r.flg[sel] = 1'b0;
    end
    next_r.flg = next_r.flg | (flag_set & ~LEVEL_MASK);

    if (s_axi_rvalid & s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid & s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
      next_r.rdata  = rd_word;
    end
  end

  // single clock straight from the core clock source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r        <= '0;
      r.st     <= ICS_RESET;
      r.sp     <= SP_RESET;
      r.pcld   <= '0;
      r.vec    <= VEC_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign core_hold     = (r.st != ICS_RUN);
  assign core_wake     = r.wake;
  assign vector_exec   = (r.st == ICS_JUMP);
  assign pc_reload     = r.pcld;
  assign stk           = r.stk;
  assign s_axi_awready = ~r.aw_got & ~r.bvalid;
  assign s_axi_wready  = ~r.w_got & ~r.bvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = ~r.rvalid;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
endmodule
`default_nettype wire

/* sim/ics_stack_model.sv */
// Purpose: data sram behind the stack port
// Assumes: read data one cycle after re
// Notes:   idle cycles show inverted data
`default_nettype none
module ics_stack_model
  import ics_pkg::*;
(
  input  wire logic     aclk,
  input  wire ics_stk_t stk,
  output var logic [7:0] stk_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  initial stk_rdata = 8'h00;
  always @(posedge aclk) begin
    if (stk.we) mem[stk.addr] <= stk.wdata;
    stk_rdata <= stk.re ? mem[stk.addr] : ~stk_rdata;
  end
endmodule
`default_nettype wire

/* sim/ics_chk.sv */
// Purpose: port timing checks
// Assumes: global enable low at return
// Notes:   bound in tb
`default_nettype none
module ics_chk
  import ics_pkg::*;
#(
  parameter int NS = NUM_SRC
) (
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire logic      instr_done,
  input wire logic      cli_exec,
  input wire logic      return_from_interrupt_instr_exec,
  input wire logic      core_hold,
  input wire logic      vector_exec,
  input wire ics_pcld_t pc_reload,
  input wire ics_stk_t  stk
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic ret;
  assign ret = instr_done && return_from_interrupt_instr_exec && !core_hold;
  AST_RST_VEC: assert property ($rose(aresetn) |=> pc_reload.load && pc_reload.addr == VEC_RESET)
    else $error("reset vector missing");
  AST_PUSH: assert property (stk.we && !$past(stk.we) |=> stk.we && stk.addr == $past(stk.addr) - 8'h01)
    else $error("push order wrong");
  AST_HOLD: assert property (stk.we && !$past(stk.we) |-> core_hold [*6])
    else $error("entry too short");
  AST_JMP: assert property (pc_reload.load && $past(stk.we, 3) |-> vector_exec [*3] ##1 !vector_exec)
    else $error("jump length wrong");
  AST_VEC: assert property (pc_reload.load && $past(stk.we, 3) |-> pc_reload.addr inside {[1:NS]})
    else $error("vector out of range");
  AST_CLI: assert property (cli_exec && !core_hold |-> ##2 !stk.we)
    else $error("entry after clear");
  AST_POP: assert property (ret |-> ##2 stk.re ##1 (stk.re && stk.addr == $past(stk.addr) + 8'h01))
    else $error("pop order wrong");
  AST_RET: assert property (ret |-> ##5 (pc_reload.load && !core_hold))
    else $error("return length wrong");
  cover property (pc_reload.load && $past(stk.we, 3));
  cover property (ret);
  cover property ($rose(core_hold) && stk.we ##1 core_hold [*8]);
endmodule
`default_nettype wire

/* sim/tb.sv */
// Purpose: self-checking bench for the sequencer
// Assumes: flag-type sources only
// Notes:   random sources and return address
`default_nettype none
module tb;
  import ics_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, instr_done, cli_exec, sei_exec, return_from_interrupt_instr_exec, core_sleep;
  logic        core_hold, core_wake, vector_exec, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  flag_set, level_req, stk_rdata, s_axi_awaddr, s_axi_araddr;
  logic [8:0]  program_counter;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  ics_pcld_t   pc_reload;
  ics_stk_t    stk;
  int          error_cnt, tests_run, tn;
  ics_sequencer   dut (.*);
  ics_stack_model stk_m (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tk = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [33:0] v);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      v = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
  endtask
  // one instruction completes
  task automatic step;
    @(posedge aclk);
    instr_done <= 1'b1;
    @(posedge aclk);
    instr_done <= 1'b0;
    @(negedge aclk);
  endtask
  // run instructions until a reload lands and the core resumes
  task automatic go(output logic [8:0] a);
    logic s, d;
    {a, s} = {9'h1FF, 1'b0};
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      if (pc_reload.load) a = pc_reload.addr;
      s |= pc_reload.load;
      if (s && !core_hold) break;
      d = !core_hold && !s;
      @(posedge aclk);
      instr_done <= d;
    end
  endtask
  task automatic pend(input logic [7:0] m);
    @(posedge aclk);
    flag_set <= m;
    @(posedge aclk);
    flag_set <= '0;
  endtask
  task automatic fin;
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic conclude;
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    conclude();
  end
  initial begin
    logic [33:0] v;
    logic [8:0]  a, pcv;
    int          k, j, n, w;
    {aresetn, instr_done, cli_exec, sei_exec, return_from_interrupt_instr_exec, core_sleep} = '0;
    {flag_set, level_req, program_counter, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_wdata, s_axi_wstrb} = {32'h0, 4'hF};
    {error_cnt, tests_run, tn, n, w} = '0;
    void'($urandom(49394));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STATUS, v);
    chk(v[7:0], SP_RESET);
    rd(8'h40, v);
    chk(v[33:32], RESP_SLVERR);
    wr(OFS_FLAGREG, 32'hFF);
    rd(OFS_FLAGREG, v);
    chk(v[31:0], 32'h80);
    fin();
    wr(OFS_FLAGREG, 32'h0);
    wr(OFS_IEN, 32'hFF);
    k = $urandom_range(6, 0);
    j = $urandom_range(7, k + 1);
    pend(8'((1 << k) | (1 << j)));
    step();
    chk(core_hold, 1'b0);
    rd(OFS_IFLAG, v);
    chk(v[31:0], (1 << k) | (1 << j));
    pcv = 9'($urandom);
    program_counter <= pcv;
    wr(OFS_FLAGREG, 32'h80);
    step();
    chk(core_hold, 1'b0);
    go(a);
    chk(a, 9'(k + 1));
    rd(OFS_IFLAG, v);
    chk(v[31:0], 1 << j);
    rd(OFS_FLAGREG, v);
    chk(v[31:0], 0);
    rd(OFS_STATUS, v);
    chk(v[7:0], SP_RESET - SP_FRAME);
    chk(stk_m.mem[SP_RESET], pcv[7:0]);
    chk(stk_m.mem[SP_RESET - SP_STEP], {PC_HI_PAD, pcv[8]});
    wr(OFS_IFLAG, 32'h0);
    rd(OFS_IFLAG, v);
    chk(v[31:0], 1 << j);
    wr(OFS_IFLAG, 1 << j);
    rd(OFS_IFLAG, v);
    chk(v[31:0], 0);
    fin();
    pend(8'(1 << k));
    return_from_interrupt_instr_exec <= 1'b1;
    go(a);
    @(posedge aclk);
    return_from_interrupt_instr_exec <= 1'b0;
    chk(a, pcv);
    rd(OFS_STATUS, v);
    chk(v[7:0], SP_RESET);
    rd(OFS_FLAGREG, v);
    chk(v[31:0], 32'h80);
    step();
    chk(core_hold, 1'b0);
    go(a);
    chk(a, 9'(k + 1));
    fin();
    wr(OFS_FLAGREG, 32'h80);
    step();
    pend(8'(1 << k));
    {instr_done, cli_exec} <= 2'b11;
    @(posedge aclk);
    {instr_done, cli_exec} <= 2'b00;
    @(negedge aclk);
    chk(core_hold, 1'b0);
    rd(OFS_FLAGREG, v);
    chk(v[31:0], 0);
    wr(OFS_FLAGREG, 32'h80);
    step();
    @(posedge aclk);
    core_sleep <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(negedge aclk);
      n += core_hold;
      w += core_wake;
    end
    @(posedge aclk);
    core_sleep <= 1'b0;
    chk(n, ENTRY_CYC + SLEEP_EXTRA + JUMP_CYC);
    chk(w, 1);
    fin();
    conclude();
  end
endmodule
bind ics_sequencer ics_chk #(.NS(NS)) chk_i (.*);
`default_nettype wire
